/* logic/flash_rewrite_pkg.sv */
// shared constants for the flash rewrite suspend control block
package flash_rewrite_pkg;
    // cpu clock rate in kHz
    localparam int unsigned CLK_KHZ = 125000;
    // suspend entry delay: 97 us plus 6 cpu clocks (longest, rounds down)
    localparam int unsigned SUSPEND_ENTRY_US = 97;
    localparam int unsigned SUSPEND_ENTRY_EXTRA = 6;
    localparam int unsigned SUSPEND_ENTRY_CYC =
        (SUSPEND_ENTRY_US * CLK_KHZ) / 1000 + SUSPEND_ENTRY_EXTRA;
    // restart delay: 3 us plus 4 cpu clocks (longest, rounds down)
    localparam int unsigned RESTART_US = 3;
    localparam int unsigned RESTART_EXTRA = 4;
    localparam int unsigned RESTART_CYC = (RESTART_US * CLK_KHZ) / 1000 + RESTART_EXTRA;
    // abort recovery period before interrupt handling may start
    localparam int unsigned ABORT_RECOVER_CYC = 16;
    // default operation lengths in cycles, shortened for simulation via parameters
    localparam int unsigned PROGRAM_CYC_DEF = 6250;
    localparam int unsigned ERASE_CYC_DEF = 50000;
    localparam int unsigned CNT_W = 32;
    // reset values of status bits
    localparam logic READY_RESET = 1'b1;
    localparam logic ERR_RESET = 1'b0;
    typedef enum logic [5:0] {
        ST_IDLE     = 6'b000001,
        ST_BUSY     = 6'b000010,
        ST_SUSP_ENT = 6'b000100,
        ST_SUSPEND  = 6'b001000,
        ST_RESUME   = 6'b010000,
        ST_ABORT    = 6'b100000
    } seq_state_e;
endpackage

/* logic/protected_bit.sv */
// protected control bit that only takes 1 after a 0-then-1 write pair
`timescale 1ns/1ps
module protected_bit (
    input wire logic clk_in,       // cpu clock
    input wire logic rst_n_in,     // sync reset, active low
    input wire logic wr_in,        // write strobe
    input wire logic wdata_in,     // written value
    input wire logic irq_in,       // interrupt taken, breaks the pair
    output logic bit_out           // current bit value
);
    typedef struct packed {
        logic armed;
        logic val;
    } pb_s;
    pb_s q, d;
    always_comb begin
        d = q;
        if (irq_in) begin
            d.armed = 1'b0;
        end
        if (wr_in) begin
            if (!wdata_in) begin
                d.val = 1'b0;
                d.armed = !irq_in;
            end else if (q.armed && !irq_in) begin
                d.val = 1'b1;
                d.armed = 1'b0;
            end else begin
                d.armed = 1'b0;
            end
        end
    end
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
    assign bit_out = q.val;
endmodule

/* logic/flash_rewrite_suspend_control.sv */
// program/erase sequencer with suspend, restart and forced abort
// What this block does
// - priority interrupt aborts and resets flash
// - erase suspends within 97us plus six clocks
// - writing zero to erase request restarts
// - no erase suspend: interrupt waits for completion
// - program suspend enabled: suspend, zero restarts
// - no program suspend: interrupt waits for completion
// - protected bits need zero then one writes
// - restart within 3us plus four clocks
// - ready bit low while busy, high after
// - error flags block commands until cleared
`timescale 1ns/1ps
module flash_rewrite_suspend_control #(
    parameter int unsigned PROGRAM_CYC = flash_rewrite_pkg::PROGRAM_CYC_DEF,
    parameter int unsigned ERASE_CYC = flash_rewrite_pkg::ERASE_CYC_DEF,
    parameter int unsigned SUSPEND_ENTRY_CYC = flash_rewrite_pkg::SUSPEND_ENTRY_CYC
) (
    input wire logic CLOCK_IN,              // cpu clock, 125 MHz
    input wire logic RESETN_IN,             // sync reset, active low
    input wire logic PROGRAM_CMD_IN,        // pulse: start auto-programming
    input wire logic ERASE_CMD_IN,          // pulse: start auto-erasure
    input wire logic CLEAR_STATUS_IN,       // pulse: clear error flags
    input wire logic FAIL_IN,               // array reports failure at completion
    input wire logic ERASE_SUSP_EN_IN,      // erase suspend function enabled
    input wire logic PROG_SUSP_EN_IN,       // program suspend function enabled
    input wire logic MASKABLE_IRQ_IN,       // maskable interrupt request level
    input wire logic PRIORITY_IRQ_IN,       // pulse: watchdog/osc-stop/voltage irq taken
    input wire logic SUSP_WR_IN,            // write strobe to suspend control reg
    input wire logic ERASE_SUSP_REQ_IN,     // erase suspend request bit value
    input wire logic PROG_SUSP_REQ_IN,      // program suspend request bit value
    input wire logic MODE_SEL_WR_IN,        // write strobe, mode select bit
    input wire logic REWRITE_DIS_WR_IN,     // write strobe, rewrite disable bit
    input wire logic MODE_AUX_WR_IN,        // write strobe, mode aux bit
    input wire logic PROT_WDATA_IN,         // data for protected bit writes
    output logic SEQUENCER_READY_OUT,       // 1 ready, 0 busy
    output logic PROGRAM_ERROR_OUT,         // program error flag
    output logic ERASE_ERROR_OUT,           // erase error flag
    output logic SUSPENDED_OUT,             // operation is suspended
    output logic IRQ_ACK_OUT,               // maskable interrupt may be serviced
    output logic FLASH_RESET_OUT,           // flash held in reset after abort
    output logic MODE_SEL_OUT,              // protected mode select bit
    output logic REWRITE_DIS_OUT,           // protected rewrite disable bit
    output logic MODE_AUX_OUT               // protected mode aux bit
);
    localparam int unsigned CW = flash_rewrite_pkg::CNT_W;

    typedef struct packed {
        flash_rewrite_pkg::seq_state_e st;
        logic is_erase;
        logic [CW-1:0] remain;
        logic [CW-1:0] timer;
        logic ready;
        logic prog_err;
        logic erase_err;
        logic suspended;
        logic irq_ack;
        logic flash_rst;
        logic esus_req;
        logic psus_req;
    } seq_s;

    seq_s q, d;
    logic mode_sel, rewrite_dis, mode_aux;

    function automatic logic [CW-1:0] to_cnt(input int unsigned v);
        to_cnt = CW'(v);
    endfunction

    // suspend allowed for the running operation kind
    function automatic logic susp_allowed(input logic is_erase, input logic esen,
                                          input logic psen);
        susp_allowed = is_erase ? esen : psen;
    endfunction

    protected_bit u_mode_sel (
        .clk_in(CLOCK_IN),
        .rst_n_in(RESETN_IN),
        .wr_in(MODE_SEL_WR_IN),
        .wdata_in(PROT_WDATA_IN),
        .irq_in(MASKABLE_IRQ_IN | PRIORITY_IRQ_IN),
        .bit_out(mode_sel)
    );
    protected_bit u_rewrite_dis (
        .clk_in(CLOCK_IN),
        .rst_n_in(RESETN_IN),
        .wr_in(REWRITE_DIS_WR_IN),
        .wdata_in(PROT_WDATA_IN),
        .irq_in(MASKABLE_IRQ_IN | PRIORITY_IRQ_IN),
        .bit_out(rewrite_dis)
    );
    protected_bit u_mode_aux (
        .clk_in(CLOCK_IN),
        .rst_n_in(RESETN_IN),
        .wr_in(MODE_AUX_WR_IN),
        .wdata_in(PROT_WDATA_IN),
        .irq_in(MASKABLE_IRQ_IN | PRIORITY_IRQ_IN),
        .bit_out(mode_aux)
    );

    always_comb begin
        d = q;
        if (SUSP_WR_IN) begin
            d.esus_req = ERASE_SUSP_REQ_IN;
            d.psus_req = PROG_SUSP_REQ_IN;
        end
        if (CLEAR_STATUS_IN) begin
            d.prog_err = 1'b0;
            d.erase_err = 1'b0;
        end
        // ack follows request while no busy operation holds it off
        d.irq_ack = MASKABLE_IRQ_IN;
        case (q.st)
            flash_rewrite_pkg::ST_IDLE: begin
                d.ready = 1'b1;
                d.flash_rst = 1'b0;
                d.suspended = 1'b0;
                if (PROGRAM_CMD_IN || ERASE_CMD_IN) begin
                    if (q.prog_err || q.erase_err || rewrite_dis) begin
                        // disabled rewrite is a command sequence error: both flags
                        if (rewrite_dis) begin
                            d.prog_err = 1'b1;
                            d.erase_err = 1'b1;
                        end
                    end else begin
                        d.st = flash_rewrite_pkg::ST_BUSY;
                        d.is_erase = ERASE_CMD_IN;
                        d.remain = to_cnt(ERASE_CMD_IN ? ERASE_CYC : PROGRAM_CYC);
                        d.timer = '0;
                        d.ready = 1'b0;
                        d.irq_ack = 1'b0;
                    end
                end
            end
            flash_rewrite_pkg::ST_BUSY: begin
                d.ready = 1'b0;
                d.remain = q.remain - 1'b1;
                d.irq_ack = 1'b0;
                if (q.remain <= to_cnt(1)) begin
                    d.st = flash_rewrite_pkg::ST_IDLE;
                    d.ready = 1'b1;
                    if (FAIL_IN) begin
                        if (q.is_erase) begin
                            d.erase_err = 1'b1;
                        end else begin
                            d.prog_err = 1'b1;
                        end
                    end
                end else if (MASKABLE_IRQ_IN &&
                             susp_allowed(q.is_erase, ERASE_SUSP_EN_IN, PROG_SUSP_EN_IN)) begin
                    d.st = flash_rewrite_pkg::ST_SUSP_ENT;
                    d.timer = '0;
                end
            end
            flash_rewrite_pkg::ST_SUSP_ENT: begin
                d.ready = 1'b0;
                d.irq_ack = 1'b0;
                d.timer = q.timer + 1'b1;
                if (q.timer >= to_cnt(SUSPEND_ENTRY_CYC - 2)) begin
                    d.st = flash_rewrite_pkg::ST_SUSPEND;
                    d.suspended = 1'b1;
                    d.irq_ack = MASKABLE_IRQ_IN;
                    // request bit reads set while suspended
                    if (q.is_erase) begin
                        d.esus_req = 1'b1;
                    end else begin
                        d.psus_req = 1'b1;
                    end
                end
            end
            flash_rewrite_pkg::ST_SUSPEND: begin
                d.ready = 1'b0;
                if (SUSP_WR_IN && !(q.is_erase ? ERASE_SUSP_REQ_IN : PROG_SUSP_REQ_IN)) begin
                    d.st = flash_rewrite_pkg::ST_RESUME;
                    d.timer = '0;
                end
            end
            flash_rewrite_pkg::ST_RESUME: begin
                d.ready = 1'b0;
                d.timer = q.timer + 1'b1;
                if (q.timer >= to_cnt(flash_rewrite_pkg::RESTART_CYC - 2)) begin
                    d.st = flash_rewrite_pkg::ST_BUSY;
                    d.suspended = 1'b0;
                    d.irq_ack = 1'b0;
                end
            end
            flash_rewrite_pkg::ST_ABORT: begin
                d.ready = 1'b0;
                d.irq_ack = 1'b0;
                d.timer = q.timer + 1'b1;
                if (q.timer >= to_cnt(flash_rewrite_pkg::ABORT_RECOVER_CYC - 1)) begin
                    d.st = flash_rewrite_pkg::ST_IDLE;
                    d.flash_rst = 1'b0;
                    d.ready = 1'b1;
                end
            end
            default: begin
                d.st = flash_rewrite_pkg::ST_IDLE;
            end
        endcase
        if (PRIORITY_IRQ_IN && q.st != flash_rewrite_pkg::ST_IDLE &&
            q.st != flash_rewrite_pkg::ST_ABORT) begin
            d.st = flash_rewrite_pkg::ST_ABORT;
            d.flash_rst = 1'b1;
            d.suspended = 1'b0;
            d.ready = 1'b0;
            d.irq_ack = 1'b0;
            d.timer = '0;
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (!RESETN_IN) begin
            q <= '0;
            q.st <= flash_rewrite_pkg::ST_IDLE;
            q.ready <= flash_rewrite_pkg::READY_RESET;
            q.prog_err <= flash_rewrite_pkg::ERR_RESET;
            q.erase_err <= flash_rewrite_pkg::ERR_RESET;
        end else begin
            q <= d;
        end
    end

    // protected bits are already flip-flop outputs inside their module
    assign SEQUENCER_READY_OUT = q.ready;
    assign PROGRAM_ERROR_OUT = q.prog_err;
    assign ERASE_ERROR_OUT = q.erase_err;
    assign SUSPENDED_OUT = q.suspended;
    assign IRQ_ACK_OUT = q.irq_ack;
    assign FLASH_RESET_OUT = q.flash_rst;
    assign MODE_SEL_OUT = mode_sel;
    assign REWRITE_DIS_OUT = rewrite_dis;
    assign MODE_AUX_OUT = mode_aux;
endmodule

/* dv/flash_rewrite_chk.sv */
// assertion checker for the flash rewrite suspend control block
`timescale 1ns/1ps
module flash_rewrite_chk #(
    parameter int unsigned PROGRAM_CYC = 20,
    parameter int unsigned ERASE_CYC = 40,
    parameter int unsigned SUSPEND_ENTRY_CYC = 8
) (
    input wire logic CLOCK_IN, RESETN_IN, PROGRAM_CMD_IN, ERASE_CMD_IN, MASKABLE_IRQ_IN,
    input wire logic PRIORITY_IRQ_IN, ERASE_SUSP_EN_IN, PROG_SUSP_EN_IN, SUSP_WR_IN,
    input wire logic ERASE_SUSP_REQ_IN, PROG_SUSP_REQ_IN, MODE_SEL_WR_IN, MODE_AUX_WR_IN,
    input wire logic PROT_WDATA_IN, SEQUENCER_READY_OUT, PROGRAM_ERROR_OUT, ERASE_ERROR_OUT,
    input wire logic SUSPENDED_OUT, IRQ_ACK_OUT, FLASH_RESET_OUT, MODE_SEL_OUT,
    input wire logic REWRITE_DIS_OUT, MODE_AUX_OUT
);
    localparam int SE_LO = SUSPEND_ENTRY_CYC;
    localparam int SE_HI = SUSPEND_ENTRY_CYC + 1;
    localparam int RS_HI = flash_rewrite_pkg::RESTART_CYC + 1;
    logic go_ok;
    logic cmd;
    assign go_ok = SEQUENCER_READY_OUT && !PROGRAM_ERROR_OUT && !ERASE_ERROR_OUT;
    assign cmd = (PROGRAM_CMD_IN || ERASE_CMD_IN) && SEQUENCER_READY_OUT;
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!RESETN_IN);
    a_prog_busy_len: assert property (
        PROGRAM_CMD_IN && !ERASE_CMD_IN && go_ok && !REWRITE_DIS_OUT && !PROG_SUSP_EN_IN
        |-> ##PROGRAM_CYC !SEQUENCER_READY_OUT ##1 SEQUENCER_READY_OUT)
        else $error("program length wrong");
    a_erase_busy_len: assert property (
        ERASE_CMD_IN && go_ok && !REWRITE_DIS_OUT && !ERASE_SUSP_EN_IN
        |-> ##ERASE_CYC !SEQUENCER_READY_OUT ##1 SEQUENCER_READY_OUT)
        else $error("erase length wrong");
    a_ack_held_busy: assert property (
        !SEQUENCER_READY_OUT && $past(!SEQUENCER_READY_OUT) && !SUSPENDED_OUT
        && !$past(SUSPENDED_OUT) |-> !IRQ_ACK_OUT)
        else $error("interrupt taken while busy");
    a_suspend_entry: assert property (
        $rose(MASKABLE_IRQ_IN) && !SEQUENCER_READY_OUT && !SUSPENDED_OUT && !FLASH_RESET_OUT
        && ERASE_SUSP_EN_IN && PROG_SUSP_EN_IN
        |-> ##[SE_LO:SE_HI] ($rose(SUSPENDED_OUT) && IRQ_ACK_OUT))
        else $error("suspend not entered in time");
    a_restart_bound: assert property (
        SUSPENDED_OUT && SUSP_WR_IN && !ERASE_SUSP_REQ_IN && !PROG_SUSP_REQ_IN
        |-> ##[1:RS_HI] !SUSPENDED_OUT)
        else $error("restart too slow");
    a_abort_reset: assert property (
        PRIORITY_IRQ_IN && !SEQUENCER_READY_OUT && !FLASH_RESET_OUT
        |=> FLASH_RESET_OUT ##15 FLASH_RESET_OUT ##1 !FLASH_RESET_OUT ##[0:1] SEQUENCER_READY_OUT)
        else $error("abort recovery wrong");
    a_prot_pair_set: assert property (
        MODE_SEL_WR_IN && PROT_WDATA_IN && !PRIORITY_IRQ_IN && !MASKABLE_IRQ_IN
        && $past(MODE_SEL_WR_IN && !PROT_WDATA_IN && !PRIORITY_IRQ_IN && !MASKABLE_IRQ_IN)
        |=> MODE_SEL_OUT)
        else $error("protected bit not set");
    a_prot_irq_block: assert property (
        MODE_AUX_WR_IN && PROT_WDATA_IN && PRIORITY_IRQ_IN && !MODE_AUX_OUT |=> !MODE_AUX_OUT)
        else $error("protected bit set across interrupt");
    a_error_refuse: assert property (
        cmd && (PROGRAM_ERROR_OUT || ERASE_ERROR_OUT) |=> SEQUENCER_READY_OUT)
        else $error("command taken with error set");
    a_disabled_cmd: assert property (
        cmd && REWRITE_DIS_OUT |=> SEQUENCER_READY_OUT && PROGRAM_ERROR_OUT && ERASE_ERROR_OUT)
        else $error("disabled command not flagged");
    c_suspend: cover property ($rose(SUSPENDED_OUT));
    c_abort: cover property ($rose(FLASH_RESET_OUT));
    c_prot_set: cover property ($rose(MODE_AUX_OUT));
endmodule
bind flash_rewrite_suspend_control flash_rewrite_chk #(.PROGRAM_CYC(PROGRAM_CYC),
    .ERASE_CYC(ERASE_CYC), .SUSPEND_ENTRY_CYC(SUSPEND_ENTRY_CYC)) u_chk (
    .CLOCK_IN(CLOCK_IN), .RESETN_IN(RESETN_IN), .PROGRAM_CMD_IN(PROGRAM_CMD_IN),
    .ERASE_CMD_IN(ERASE_CMD_IN), .MASKABLE_IRQ_IN(MASKABLE_IRQ_IN),
    .PRIORITY_IRQ_IN(PRIORITY_IRQ_IN), .ERASE_SUSP_EN_IN(ERASE_SUSP_EN_IN),
    .PROG_SUSP_EN_IN(PROG_SUSP_EN_IN), .SUSP_WR_IN(SUSP_WR_IN),
    .ERASE_SUSP_REQ_IN(ERASE_SUSP_REQ_IN), .PROG_SUSP_REQ_IN(PROG_SUSP_REQ_IN),
    .MODE_SEL_WR_IN(MODE_SEL_WR_IN), .MODE_AUX_WR_IN(MODE_AUX_WR_IN),
    .PROT_WDATA_IN(PROT_WDATA_IN), .SEQUENCER_READY_OUT(SEQUENCER_READY_OUT),
    .PROGRAM_ERROR_OUT(PROGRAM_ERROR_OUT), .ERASE_ERROR_OUT(ERASE_ERROR_OUT),
    .SUSPENDED_OUT(SUSPENDED_OUT), .IRQ_ACK_OUT(IRQ_ACK_OUT),
    .FLASH_RESET_OUT(FLASH_RESET_OUT), .MODE_SEL_OUT(MODE_SEL_OUT),
    .REWRITE_DIS_OUT(REWRITE_DIS_OUT), .MODE_AUX_OUT(MODE_AUX_OUT));

/* dv/cpu_irq_model.sv */
// cpu model: raises a maskable interrupt and restarts a suspended operation
`timescale 1ns/1ps
module cpu_irq_model #(
    parameter int HANDLER_CYC = 4
) (
    input wire logic clk_in,        // cpu clock
    input wire logic raise_in,      // bench asks for an interrupt
    input wire logic ack_in,        // interrupt may be serviced
    input wire logic suspended_in,  // operation suspended
    output logic irq_out = 1'b0,    // maskable request level
    output logic wr_out = 1'b0,     // suspend register write strobe
    output logic erase_req_out = 1'b0, // erase suspend request bit
    output logic prog_req_out = 1'b0   // program suspend request bit
);
    int wait_q = 0;
    always @(posedge clk_in) begin
        wr_out <= 1'b0;
        if (raise_in) begin
            irq_out <= 1'b1;
        end else if (irq_out && ack_in && !suspended_in) begin
            irq_out <= 1'b0;
        end else if (irq_out && ack_in) begin
            if (wait_q == HANDLER_CYC) begin
                irq_out <= 1'b0;
                wr_out <= 1'b1;
                wait_q <= 0;
            end else begin
                wait_q <= wait_q + 1;
            end
        end
    end
endmodule

/* dv/flash_rewrite_suspend_control_tb.sv */
// self-checking bench for the flash rewrite suspend control block
`timescale 1ns/1ps
module flash_rewrite_suspend_control_tb;
    localparam int PCYC = 20;
    localparam int ECYC = 40;
    localparam int RCYC = flash_rewrite_pkg::RESTART_CYC;
    localparam int SUSP_GAP = 4;
    logic clk = 1'b0, rst_n = 1'b0, prog_cmd = 1'b0, erase_cmd = 1'b0, clr = 1'b0;
    logic fail = 1'b0, esus_en = 1'b0, psus_en = 1'b0, pirq = 1'b0, wdata = 1'b0;
    logic raise = 1'b0, mirq, swr, ereq, preq, ready, perr, eerr, susp, ack, frst;
    logic [2:0] wr = 3'h0;
    logic [2:0] prot;
    int mismatches = 0, checks_done = 0, susp_cyc = 0, ack_busy = 0, ack_cnt = 0, rst_cyc = 0;
    int busy_cyc = 0;
    always #4 clk = ~clk;
    flash_rewrite_suspend_control #(.PROGRAM_CYC(PCYC), .ERASE_CYC(ECYC),
        .SUSPEND_ENTRY_CYC(8)) dut (.CLOCK_IN(clk), .RESETN_IN(rst_n),
        .PROGRAM_CMD_IN(prog_cmd), .ERASE_CMD_IN(erase_cmd), .CLEAR_STATUS_IN(clr),
        .FAIL_IN(fail), .ERASE_SUSP_EN_IN(esus_en), .PROG_SUSP_EN_IN(psus_en),
        .MASKABLE_IRQ_IN(mirq), .PRIORITY_IRQ_IN(pirq), .SUSP_WR_IN(swr),
        .ERASE_SUSP_REQ_IN(ereq), .PROG_SUSP_REQ_IN(preq), .MODE_SEL_WR_IN(wr[0]),
        .REWRITE_DIS_WR_IN(wr[1]), .MODE_AUX_WR_IN(wr[2]), .PROT_WDATA_IN(wdata),
        .SEQUENCER_READY_OUT(ready), .PROGRAM_ERROR_OUT(perr), .ERASE_ERROR_OUT(eerr),
        .SUSPENDED_OUT(susp), .IRQ_ACK_OUT(ack), .FLASH_RESET_OUT(frst),
        .MODE_SEL_OUT(prot[0]), .REWRITE_DIS_OUT(prot[1]), .MODE_AUX_OUT(prot[2]));
    cpu_irq_model cpu (.clk_in(clk), .raise_in(raise), .ack_in(ack), .suspended_in(susp),
        .irq_out(mirq), .wr_out(swr), .erase_req_out(ereq), .prog_req_out(preq));
    always @(posedge clk) begin
        susp_cyc += (susp === 1'b1);
        ack_cnt += (ack === 1'b1);
        ack_busy += (ack === 1'b1 && ready === 1'b0 && susp === 1'b0);
        rst_cyc += (frst === 1'b1);
        busy_cyc += (ready === 1'b0);
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic start_op(input bit is_erase);
        @(posedge clk);
        erase_cmd <= is_erase;
        prog_cmd <= !is_erase;
        @(posedge clk);
        erase_cmd <= 1'b0;
        prog_cmd <= 1'b0;
    endtask
    // waits are bounded; running out ends the run
    task automatic wait_ready(output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (ready !== 1'b1 && n < 3000);
        if (n >= 3000) begin
            mismatches++;
            wrap_up();
        end
    endtask
    task automatic pulse(input bit is_irq);
        @(posedge clk);
        pirq <= is_irq;
        clr <= !is_irq;
        @(posedge clk);
        pirq <= 1'b0;
        clr <= 1'b0;
        #1;
    endtask
    task automatic pwrite(input int sel, input logic d0, input logic d1, input logic irq);
        @(posedge clk);
        wr[sel] <= 1'b1;
        wdata <= d0;
        @(posedge clk);
        wdata <= d1;
        pirq <= irq;
        @(posedge clk);
        wr[sel] <= 1'b0;
        pirq <= 1'b0;
        #1;
    endtask
    initial begin
        int n;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        check("ready_rst", ready, 1'b1);
        check("prot_rst", {prot, perr, eerr}, 5'h00);
        // program and erase, suspend off then on, interrupt in mid-operation
        // erases follow programs
        for (int c = 0; c < 4; c++) begin
            @(posedge clk);
            esus_en <= c[1];
            psus_en <= c[1];
            susp_cyc = 0;
            ack_busy = 0;
            ack_cnt = 0;
            busy_cyc = 0;
            start_op(c[0]);
            repeat (SUSP_GAP) @(posedge clk);
            raise <= 1'b1;
            @(posedge clk);
            raise <= 1'b0;
            wait_ready(n);
            repeat (3) @(posedge clk);
            check("ack_seen", ack_cnt != 0, 1'b1);
            check("ack_busy", ack_busy, 0);
            if (c[1]) begin
                check("susp_len", susp_cyc >= RCYC && susp_cyc <= RCYC + 12, 1'b1);
                check("op_longer", busy_cyc > (c[0] ? ECYC : PCYC) + RCYC, 1'b1);
            end else begin
                check("op_len", busy_cyc, c[0] ? ECYC : PCYC);
            end
        end
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            fail <= 1'b1;
            start_op(k[0]);
            wait_ready(n);
            check("err_flag", {perr, eerr}, k[0] ? 2'b01 : 2'b10);
            @(posedge clk);
            fail <= 1'b0;
            start_op(1'b0);
            repeat (2) @(posedge clk);
            #1;
            check("refused", ready, 1'b1);
            pulse(1'b0);
            check("cleared", {perr, eerr}, 2'b00);
        end
        // priority interrupt during a suspendable erase
        rst_cyc = 0;
        start_op(1'b1);
        repeat (3) @(posedge clk);
        pulse(1'b1);
        wait_ready(n);
        check("reset_len", rst_cyc, flash_rewrite_pkg::ABORT_RECOVER_CYC);
        check("abort_err", {perr, eerr}, 2'b00);
        start_op(1'b1);
        wait_ready(n);
        check("rerun_err", {perr, eerr}, 2'b00);
        for (int s = 0; s < 3; s++) begin
            pwrite(s, 1'b1, 1'b1, 1'b0);
            check("prot_unarmed", prot[s], 1'b0);
            if (s == 2) begin
                pwrite(s, 1'b0, 1'b1, 1'b1);
                check("prot_irq", prot[s], 1'b0);
            end
            pwrite(s, 1'b0, 1'b1, 1'b0);
            check("prot_set", prot[s], 1'b1);
        end
        start_op(1'b0);
        @(posedge clk);
        #1;
        check("dis_err", {perr, eerr, ready}, 3'b111);
        wrap_up();
    end
endmodule
